// [common/dlc_pkg.sv]
//----------------------------------------------------------------------
// Purpose: Constants and types of the dual channel light conversion
// Assumes: Link clock period 125 ns, system clock 125 MHz
// Notes:   Shared by core, converter sequencer and testbench
//----------------------------------------------------------------------
package dlc_pkg;

  localparam int unsigned T_LINK_NS = 125;
  localparam int unsigned T_INT0_NS = 13_700_000;
  localparam int unsigned T_INT1_NS = 101_000_000;
  localparam int unsigned T_INT2_NS = 402_000_000;
  localparam int unsigned INT0_CYC  = T_INT0_NS / T_LINK_NS;
  localparam int unsigned INT1_CYC  = T_INT1_NS / T_LINK_NS;
  localparam int unsigned INT2_CYC  = T_INT2_NS / T_LINK_NS;
  localparam int unsigned TMR_W     = 22;

  localparam logic [15:0] SAT_INT0 = 16'h13B7;
  localparam logic [15:0] SAT_INT1 = 16'h9139;
  localparam logic [15:0] SAT_FULL = 16'hFFFF;
  localparam logic [15:0] STEP_LO  = 16'h0001;
  localparam logic [15:0] STEP_HI  = 16'h0010;
  localparam logic [15:0] RST_DATA = 16'h0000;

  localparam logic [1:0] SEL_INT0 = 2'h0;
  localparam logic [1:0] SEL_INT1 = 2'h1;
  localparam logic [1:0] SEL_INT2 = 2'h2;
  localparam logic [1:0] SEL_MAN  = 2'h3;

  localparam logic [6:0] ADDR_GND   = 7'h10;
  localparam logic [6:0] ADDR_FLOAT = 7'h11;
  localparam logic [6:0] ADDR_VDD   = 7'h12;
  localparam logic [8:0] BUS_KHZ_SMB = 9'h064;
  localparam logic [8:0] BUS_KHZ_I2C = 9'h190;
  localparam logic [3:0] PERS_MAX    = 4'hF;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_INTEG = 2'b01,
    ST_XFER  = 2'b11
  } dlc_conv_st_t;

endpackage

// [common/dlc_conv_if.sv]
//----------------------------------------------------------------------
// Purpose: Carrier between core and converter sequencer
// Assumes: Config driven on ref_clk, results on the link clock
// Notes:   Hold words stay stable between done toggles
//----------------------------------------------------------------------
`timescale 1ns/1ps
interface dlc_conv_if;
  logic        rst_req;
  logic        power_on;
  logic        gain_hi;
  logic [1:0]  integ_sel;
  logic        manual_go;
  logic [15:0] ch0_hold;
  logic [15:0] ch1_hold;
  logic        done_tgl;

  modport core (output rst_req, power_on, gain_hi, integ_sel, manual_go,
                input  ch0_hold, ch1_hold, done_tgl);
  modport integ (input  rst_req, power_on, gain_hi, integ_sel, manual_go,
                 output ch0_hold, ch1_hold, done_tgl);
endinterface

// [rtl/dlc_integ.sv]
//----------------------------------------------------------------------
// Purpose: Integration sequencer on the converter clock
// Assumes: Pulse inputs mark one photodiode charge packet each
// Notes:   Config is synchronised; gain and select latched at each cycle start, power_on and manual_go act live
//----------------------------------------------------------------------
`timescale 1ns/1ps
module dlc_integ
  import dlc_pkg::*;
#(
  parameter int unsigned INT0_CYC_P = INT0_CYC,
  parameter int unsigned INT1_CYC_P = INT1_CYC,
  parameter int unsigned INT2_CYC_P = INT2_CYC
)
(
  input wire logic  conv_clk,
  input wire logic  ch0_pulse,
  input wire logic  ch1_pulse,
  dlc_conv_if.integ cif
);
  logic [4:0]       cfg_s1_reg, cfg_s2_reg, cfg_s3_reg, cfg_ok_reg;
  logic             rst_s1_reg, rst_s2_reg;
  logic [1:0]       pls_s1_reg, pls_s2_reg, pls_s3_reg, rise;
  dlc_conv_st_t     st_reg, st_next;
  logic [TMR_W-1:0] tmr_reg, tmr_next, end_reg, end_next;
  logic [15:0]      cnt0_reg, cnt0_next, cnt1_reg, cnt1_next;
  logic [15:0]      lim_reg, lim_next, step_reg, step_next;
  logic [15:0]      hold0_reg, hold0_next, hold1_reg, hold1_next;
  logic             man_reg, man_next, tgl_reg, tgl_next;
  logic             rst_c, pw_s, gain_s, man_s;
  logic [1:0]       sel_s;

  function automatic logic [15:0] sat_add(logic [15:0] a, logic [15:0] s,
                                          logic [15:0] lim);
    logic [16:0] sum;
    sum = {1'b0, a} + {1'b0, s};
    return (sum > {1'b0, lim}) ? lim : sum[15:0];
  endfunction

  //--------------------------------------------------------------------
  // Synchronisers
  //--------------------------------------------------------------------
  // Reset asserts at once, releases on the converter clock
  always_ff @(posedge conv_clk or posedge cif.rst_req)
  begin
    if (cif.rst_req)
    begin
      rst_s1_reg <= 1'b1;
      rst_s2_reg <= 1'b1;
    end
    else
    begin
      rst_s1_reg <= 1'b0;
      rst_s2_reg <= rst_s1_reg;
    end
  end

  always_ff @(posedge conv_clk)
  begin
    cfg_s1_reg <= {cif.power_on, cif.gain_hi, cif.integ_sel, cif.manual_go};
    cfg_s2_reg <= cfg_s1_reg;
    cfg_s3_reg <= cfg_s2_reg;
    // Bits may land a cycle apart: take the word once two samples agree
    cfg_ok_reg <= (cfg_s2_reg == cfg_s3_reg) ? cfg_s2_reg : cfg_ok_reg;
    pls_s1_reg <= {ch1_pulse, ch0_pulse};
    pls_s2_reg <= pls_s1_reg;
    pls_s3_reg <= pls_s2_reg;
  end

  assign rst_c = rst_s2_reg;
  assign {pw_s, gain_s, sel_s, man_s} = cfg_ok_reg;
  assign rise = pls_s2_reg & ~pls_s3_reg;

  //--------------------------------------------------------------------
  // Sequencer
  //--------------------------------------------------------------------
  always_comb
  begin
    st_next    = st_reg;
    tmr_next   = tmr_reg;
    end_next   = end_reg;
    cnt0_next  = cnt0_reg;
    cnt1_next  = cnt1_reg;
    lim_next   = lim_reg;
    step_next  = step_reg;
    hold0_next = hold0_reg;
    hold1_next = hold1_reg;
    man_next   = man_reg;
    tgl_next   = tgl_reg;
    unique case (st_reg)
      ST_IDLE:
        if (pw_s && (sel_s != SEL_MAN || man_s))
        begin
          st_next   = ST_INTEG;
          tmr_next  = '0;
          cnt0_next = RST_DATA;
          cnt1_next = RST_DATA;
          step_next = gain_s ? STEP_HI : STEP_LO;
          man_next  = (sel_s == SEL_MAN);
          unique case (sel_s)
            SEL_INT0:
            begin
              end_next = TMR_W'(INT0_CYC_P - 1);
              lim_next = SAT_INT0;
            end
            SEL_INT1:
            begin
              end_next = TMR_W'(INT1_CYC_P - 1);
              lim_next = SAT_INT1;
            end
            SEL_INT2:
            begin
              end_next = TMR_W'(INT2_CYC_P - 1);
              lim_next = SAT_FULL;
            end
            SEL_MAN:
            begin
              end_next = '1;
              lim_next = SAT_FULL;
            end
          endcase
        end
      ST_INTEG:
        if (!pw_s)
          st_next = ST_IDLE;
        else
        begin
          cnt0_next = sat_add(cnt0_reg, rise[0] ? step_reg : 16'h0000, lim_reg);
          cnt1_next = sat_add(cnt1_reg, rise[1] ? step_reg : 16'h0000, lim_reg);
          tmr_next  = tmr_reg + 1'b1;
          if (man_reg ? !man_s : (tmr_reg == end_reg))
            st_next = ST_XFER;
        end
      ST_XFER:
      begin
        hold0_next = cnt0_reg;
        hold1_next = cnt1_reg;
        tgl_next   = ~tgl_reg;
        st_next    = ST_IDLE;
      end
      default:
        st_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge conv_clk)
  begin
    if (rst_c)
    begin
      st_reg    <= ST_IDLE;
      tmr_reg   <= '0;
      end_reg   <= '0;
      cnt0_reg  <= RST_DATA;
      cnt1_reg  <= RST_DATA;
      lim_reg   <= SAT_FULL;
      step_reg  <= STEP_LO;
      hold0_reg <= RST_DATA;
      hold1_reg <= RST_DATA;
      man_reg   <= 1'b0;
      tgl_reg   <= 1'b0;
    end
    else
    begin
      st_reg    <= st_next;
      tmr_reg   <= tmr_next;
      end_reg   <= end_next;
      cnt0_reg  <= cnt0_next;
      cnt1_reg  <= cnt1_next;
      lim_reg   <= lim_next;
      step_reg  <= step_next;
      hold0_reg <= hold0_next;
      hold1_reg <= hold1_next;
      man_reg   <= man_next;
      tgl_reg   <= tgl_next;
    end
  end

  assign cif.ch0_hold = hold0_reg;
  assign cif.ch1_hold = hold1_reg;
  assign cif.done_tgl = tgl_reg;

  //--------------------------------------------------------------------
  // Assertions
  //--------------------------------------------------------------------
  default clocking cb @(posedge conv_clk); endclocking
  default disable iff (rst_c);

  property p_joint_start;
    st_reg == ST_IDLE && st_next == ST_INTEG
      |=> cnt0_reg == 16'h0000 && cnt1_reg == 16'h0000 && tmr_reg == '0;
  endproperty
  a_joint_start: assert property (p_joint_start) else $error("channels start apart");
  property p_xfer_copy;
    st_reg == ST_XFER
      |=> hold0_reg == $past(cnt0_reg) && hold1_reg == $past(cnt1_reg) && tgl_reg != $past(tgl_reg);
  endproperty
  a_xfer_copy: assert property (p_xfer_copy) else $error("hold words not copied");
  property p_restart;
    st_reg == ST_XFER ##1 (pw_s && sel_s != SEL_MAN) |=> st_reg == ST_INTEG;
  endproperty
  a_restart: assert property (p_restart) else $error("no automatic restart");
  property p_gain_step;
    st_reg == ST_INTEG && pw_s && rise[0] && cnt0_reg <= lim_reg - step_reg
      |=> cnt0_reg == $past(cnt0_reg) + $past(step_reg);
  endproperty
  a_gain_step: assert property (p_gain_step) else $error("gain step wrong");
  property p_pdown;
    !pw_s |=> st_reg == ST_IDLE;
  endproperty
  a_pdown: assert property (p_pdown) else $error("converting in power-down");
  property p_sat;
    cnt0_reg <= lim_reg && cnt1_reg <= lim_reg;
  endproperty
  a_sat: assert property (p_sat) else $error("count above saturation");
  c_xfer: cover property (st_reg == ST_XFER ##2 st_reg == ST_INTEG);
endmodule

// [rtl/dlc_core.sv]
//----------------------------------------------------------------------
// Purpose: Result registers, threshold interrupt and address strap
// Assumes: Config and threshold ports driven from ref_clk logic
// Notes:   Converter sequencer runs on conv_clk inside dlc_integ
//----------------------------------------------------------------------
`timescale 1ns/1ps
module dlc_core
  import dlc_pkg::*;
#(
  parameter int unsigned INT0_CYC_P = INT0_CYC,
  parameter int unsigned INT1_CYC_P = INT1_CYC,
  parameter int unsigned INT2_CYC_P = INT2_CYC
)
(
  input  wire logic        ref_clk,
  input  wire logic        conv_clk,
  input  wire logic        sys_rst,
  input  wire logic        ch0_pulse,
  input  wire logic        ch1_pulse,
  input  wire logic        power_on,
  input  wire logic        gain_hi,
  input  wire logic [1:0]  integ_sel,
  input  wire logic        manual_go,
  input  wire logic [15:0] thr_low,
  input  wire logic [15:0] thr_high,
  input  wire logic [3:0]  persist,
  input  wire logic        int_en,
  input  wire logic        int_clear,
  input  wire logic        alert_ack,
  input  wire logic        variant_smb,
  input  wire logic        addr_sel_gnd,
  input  wire logic        addr_sel_vdd,
  output logic      [15:0] ch0_data,
  output logic      [15:0] ch1_data,
  output logic             data_new,
  output logic             int_o,
  output logic             int_oe,
  output logic      [6:0]  slave_addr,
  output logic      [8:0]  bus_khz
);
  dlc_conv_if cif ();

  logic        rst_req_reg, pw_reg, gain_reg, man_reg;
  logic [1:0]  sel_reg;
  logic [2:0]  pin_s1_reg, pin_s2_reg;
  logic        tgl_s1_reg, tgl_s2_reg, tgl_s3_reg, new_res;
  logic [15:0] ch0_reg, ch0_next, ch1_reg, ch1_next;
  logic        new_reg, new_next;
  logic [3:0]  pers_reg, pers_next;
  logic        flag_reg, flag_next, out_win, hit, clr;
  logic        lock_reg, lock_next, var_reg, var_next;
  logic [6:0]  addr_reg, addr_next;
  logic [8:0]  khz_reg, khz_next;

  function automatic logic [6:0] addr_decode(logic gnd, logic vdd);
    if (gnd)
      return ADDR_GND;
    else if (vdd)
      return ADDR_VDD;
    else
      return ADDR_FLOAT;
  endfunction

  //--------------------------------------------------------------------
  // Converter config and sequencer
  //--------------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      rst_req_reg <= 1'b1;
      pw_reg      <= 1'b0;
      gain_reg    <= 1'b0;
      sel_reg     <= SEL_INT2;
      man_reg     <= 1'b0;
    end
    else
    begin
      rst_req_reg <= 1'b0;
      pw_reg      <= power_on;
      gain_reg    <= gain_hi;
      sel_reg     <= integ_sel;
      man_reg     <= manual_go;
    end
  end

  assign cif.rst_req   = rst_req_reg;
  assign cif.power_on  = pw_reg;
  assign cif.gain_hi   = gain_reg;
  assign cif.integ_sel = sel_reg;
  assign cif.manual_go = man_reg;

  dlc_integ #(
    .INT0_CYC_P (INT0_CYC_P),
    .INT1_CYC_P (INT1_CYC_P),
    .INT2_CYC_P (INT2_CYC_P)
  ) u_integ (
    .conv_clk  (conv_clk),
    .ch0_pulse (ch0_pulse),
    .ch1_pulse (ch1_pulse),
    .cif       (cif)
  );

  //--------------------------------------------------------------------
  // Synchronisers
  //--------------------------------------------------------------------
  // Straps keep sampling in reset so the latch sees the pins
  always_ff @(posedge ref_clk)
  begin
    pin_s1_reg <= {variant_smb, addr_sel_vdd, addr_sel_gnd};
    pin_s2_reg <= pin_s1_reg;
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      tgl_s1_reg <= 1'b0;
      tgl_s2_reg <= 1'b0;
      tgl_s3_reg <= 1'b0;
    end
    else
    begin
      tgl_s1_reg <= cif.done_tgl;
      tgl_s2_reg <= tgl_s1_reg;
      tgl_s3_reg <= tgl_s2_reg;
    end
  end

  assign new_res = tgl_s2_reg ^ tgl_s3_reg;

  //--------------------------------------------------------------------
  // Result registers
  //--------------------------------------------------------------------
  always_comb
  begin
    ch0_next = ch0_reg;
    ch1_next = ch1_reg;
    new_next = new_res;
    if (new_res)
    begin
      ch0_next = cif.ch0_hold;
      ch1_next = cif.ch1_hold;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      ch0_reg <= RST_DATA;
      ch1_reg <= RST_DATA;
      new_reg <= 1'b0;
    end
    else
    begin
      ch0_reg <= ch0_next;
      ch1_reg <= ch1_next;
      new_reg <= new_next;
    end
  end

  //--------------------------------------------------------------------
  // Threshold and interrupt
  //--------------------------------------------------------------------
  assign out_win = (cif.ch0_hold > thr_high) || (cif.ch0_hold < thr_low);
  assign clr     = int_clear || (var_reg && alert_ack);

  always_comb
  begin
    pers_next = pers_reg;
    hit       = 1'b0;
    if (new_res)
    begin
      if (!out_win)
        pers_next = 4'h0;
      else if (pers_reg != PERS_MAX)
        pers_next = pers_reg + 4'h1;
      hit = int_en && ((persist == 4'h0)
            || (out_win && ({1'b0, pers_reg} + 5'h01 >= {1'b0, persist})));
    end
    flag_next = flag_reg;
    if (hit)
      flag_next = 1'b1;
    else if (clr)
      flag_next = 1'b0;
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      pers_reg <= 4'h0;
      flag_reg <= 1'b0;
    end
    else
    begin
      pers_reg <= pers_next;
      flag_reg <= flag_next;
    end
  end

  //--------------------------------------------------------------------
  // Address and variant strap
  //--------------------------------------------------------------------
  always_comb
  begin
    lock_next = 1'b1;
    var_next  = var_reg;
    addr_next = addr_reg;
    khz_next  = khz_reg;
    if (!lock_reg)
    begin
      var_next  = pin_s2_reg[2];
      addr_next = addr_decode(pin_s2_reg[0], pin_s2_reg[1]);
      khz_next  = pin_s2_reg[2] ? BUS_KHZ_SMB : BUS_KHZ_I2C;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      lock_reg <= 1'b0;
      var_reg  <= 1'b0;
      addr_reg <= ADDR_FLOAT;
      khz_reg  <= BUS_KHZ_I2C;
    end
    else
    begin
      lock_reg <= lock_next;
      var_reg  <= var_next;
      addr_reg <= addr_next;
      khz_reg  <= khz_next;
    end
  end

  //--------------------------------------------------------------------
  // Outputs
  //--------------------------------------------------------------------
  logic zero_reg;

  always_ff @(posedge ref_clk)
  begin
    zero_reg <= 1'b0;
  end

  assign ch0_data   = ch0_reg;
  assign ch1_data   = ch1_reg;
  assign data_new   = new_reg;
  assign int_o      = zero_reg;
  assign int_oe     = flag_reg;
  assign slave_addr = addr_reg;
  assign bus_khz    = khz_reg;

  //--------------------------------------------------------------------
  // Assertions
  //--------------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  property p_xfer;
    new_res |=> ch0_data == $past(cif.ch0_hold) && ch1_data == $past(cif.ch1_hold)
      && data_new;
  endproperty
  a_xfer: assert property (p_xfer) else $error("result not transferred");
  property p_dbuf;
    !new_res |=> $stable(ch0_data) && $stable(ch1_data) && !data_new;
  endproperty
  a_dbuf: assert property (p_dbuf) else $error("result changed between transfers");
  property p_thr;
    new_res && int_en && persist == 4'h1 && out_win |=> int_oe;
  endproperty
  a_thr: assert property (p_thr) else $error("threshold miss");
  property p_persist;
    new_res && int_en && !int_oe && pers_reg == 4'h0 && persist == 4'h3 |=> !int_oe;
  endproperty
  a_persist: assert property (p_persist) else $error("fired before persistence");
  property p_level;
    int_oe && !int_clear && !(var_reg && alert_ack) |=> int_oe;
  endproperty
  a_level: assert property (p_level) else $error("interrupt dropped uncleared");
  property p_od;
    $rose(int_oe) |-> $past(new_res) && !int_o;
  endproperty
  a_od: assert property (p_od) else $error("interrupt pin misdriven");
  property p_addr;
    lock_reg |=> $stable(slave_addr);
  endproperty
  a_addr: assert property (p_addr) else $error("address moved after strap");
  property p_bus;
    lock_reg |-> bus_khz == (var_reg ? BUS_KHZ_SMB : BUS_KHZ_I2C);
  endproperty
  a_bus: assert property (p_bus) else $error("bus rate wrong");
  property p_restart;
    new_res && !out_win |=> pers_reg == 4'h0;
  endproperty
  a_restart: assert property (p_restart) else $error("persistence not restarted");
  c_new: cover property (new_res ##1 data_new);
  c_int: cover property ($rose(int_oe));
  c_alert: cover property (int_oe && var_reg && alert_ack ##1 !int_oe);
endmodule

// [tb/dlc_host_model.sv]
//----------------------------------------------------------------------
// Purpose: Far side model: light pulses and pulled-up interrupt line
// Assumes: Packet pulses free of the converter clock, 400 ns high/low
// Notes:   ir_en gates the infrared channel onto the same packets
//----------------------------------------------------------------------
`timescale 1ns/1ps
module dlc_host_model (
  input  wire logic pulse_en,
  input  wire logic ir_en,
  input  wire logic int_o,
  input  wire logic int_oe,
  output logic      ch0_pulse,
  output logic      ch1_pulse,
  output logic      int_line
);
  // Board pull-up, device only sinks
  assign int_line = int_oe ? int_o : 1'b1;
  assign ch1_pulse = ch0_pulse & ir_en;
  initial
  begin
    ch0_pulse = 1'b0;
    forever
    begin
      #400;
      ch0_pulse = pulse_en & ~ch0_pulse;
    end
  end
endmodule

// [tb/dlc_core_tb.sv]
//----------------------------------------------------------------------
// Purpose: Self-checking bench of the light conversion core
// Assumes: Short integration lengths 20/40/80 link cycles
// Notes:   Inputs change on the falling edge of ref_clk
//----------------------------------------------------------------------
`timescale 1ns/1ps
module dlc_core_tb;
  import dlc_pkg::*;
  logic ref_clk, conv_clk, sys_rst, ch0_pulse, ch1_pulse, power_on, gain_hi;
  logic [1:0] integ_sel;
  logic [15:0] thr_low, thr_high, ch0_data, ch1_data;
  logic [3:0] persist;
  logic int_en, int_clear, alert_ack, variant_smb, addr_sel_gnd, addr_sel_vdd;
  logic data_new, int_o, int_oe, int_line, pulse_en, ir_en, manual_go;
  logic [6:0] slave_addr;
  logic [8:0] bus_khz;
  int err_total, check_count, tick, n;
  logic [15:0] v;

  dlc_core #(.INT0_CYC_P(20), .INT1_CYC_P(40), .INT2_CYC_P(80)) i_dlc_core (
    .ref_clk(ref_clk), .conv_clk(conv_clk), .sys_rst(sys_rst),
    .ch0_pulse(ch0_pulse), .ch1_pulse(ch1_pulse), .power_on(power_on),
    .gain_hi(gain_hi), .integ_sel(integ_sel), .manual_go(manual_go),
    .thr_low(thr_low), .thr_high(thr_high), .persist(persist),
    .int_en(int_en), .int_clear(int_clear), .alert_ack(alert_ack),
    .variant_smb(variant_smb), .addr_sel_gnd(addr_sel_gnd),
    .addr_sel_vdd(addr_sel_vdd), .ch0_data(ch0_data), .ch1_data(ch1_data),
    .data_new(data_new), .int_o(int_o), .int_oe(int_oe),
    .slave_addr(slave_addr), .bus_khz(bus_khz));

  dlc_host_model i_dlc_host_model (.pulse_en(pulse_en), .ir_en(ir_en),
    .int_o(int_o), .int_oe(int_oe), .ch0_pulse(ch0_pulse),
    .ch1_pulse(ch1_pulse), .int_line(int_line));

  initial
  begin
    ref_clk = 1'b0;
    forever
    begin
      #4 ref_clk = ~ref_clk;
    end
  end
  initial
  begin
    conv_clk = 1'b0;
    #17;
    forever
    begin
      #62.5 conv_clk = ~conv_clk;
    end
  end
  // Hang guard
  always @(posedge ref_clk)
  begin
    tick <= tick + 1;
    if (tick == 60000)
    begin
      err_total = err_total + 1;
      results();
    end
  end

  task automatic results();
    if (err_total == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    check_count = check_count + 1;
    if (seen !== exp)
    begin
      err_total = err_total + 1;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge ref_clk);
  endtask
  task automatic wait_new();
    n = 0;
    do
    begin
      @(posedge ref_clk);
      #1;
      n = n + 1;
    end while (data_new !== 1'b1 && n < 3000);
    if (n >= 3000)
      chk("data_new", {15'h0, data_new}, 16'h0001);
  endtask
  task automatic count_new(input int k);
    n = 0;
    repeat (k)
    begin
      @(posedge ref_clk);
      #1;
      n = n + (data_new === 1'b1);
    end
  endtask
  task automatic do_reset();
    sys_rst = 1'b1;
    repeat (5) @(negedge conv_clk);
    cyc(1);
    sys_rst = 1'b0;
  endtask

  //--------------------------------------------------------------------
  // Scenarios
  //--------------------------------------------------------------------
  task automatic t_reset();
    chk("ch0 reset", ch0_data, RST_DATA);
    chk("ch1 reset", ch1_data, RST_DATA);
    chk("int_oe reset", {15'h0, int_oe}, 16'h0000);
    cyc(3);
    chk("addr float", {9'h0, slave_addr}, 16'h0011);
    chk("khz i2c", {7'h0, bus_khz}, 16'h0190);
  endtask
  task automatic t_conv();
    pulse_en = 1'b1;
    ir_en = 1'b1;
    wait_new();
    wait_new();
    chk("ch1 same period", ch1_data, ch0_data);
    chk("ch0 nonzero", {15'h0, ch0_data === 16'h0000}, 16'h0000);
    chk("high gain step", {12'h0, ch0_data[3:0]}, 16'h0000);
    v = ch0_data;
    cyc(100);
    chk("result held", ch0_data, v);
    cyc(1);
    ir_en = 1'b0;
    gain_hi = 1'b0;
    wait_new();
    wait_new();
    chk("ch1 dark", ch1_data, 16'h0000);
    chk("low gain small", {15'h0, ch0_data < STEP_HI && ch0_data > 0}, 16'h0001);
    for (int s = 0; s < 3; s++)
    begin
      cyc(1);
      integ_sel = s[1:0];
      wait_new();
      wait_new();
      wait_new();
      v = 16'((((20 << s) + 2) * 125) / 8);
      chk("cycle length", {15'h0, n > v - 6 && n < v + 6}, 16'h0001);
    end
    cyc(1);
    integ_sel = SEL_INT0;
  endtask
  task automatic t_pwr();
    cyc(1);
    power_on = 1'b0;
    count_new(2000);
    chk("no result off", n[15:0], 16'h0000);
    cyc(1);
    power_on = 1'b1;
    wait_new();
  endtask
  task automatic t_man();
    cyc(1);
    integ_sel = SEL_MAN;
    wait_new();
    count_new(1000);
    chk("manual waits", n[15:0], 16'h0000);
    cyc(1);
    manual_go = 1'b1;
    cyc(400);
    manual_go = 1'b0;
    wait_new();
    chk("manual count", {15'h0, ch0_data > 0 && ch0_data < STEP_HI}, 16'h0001);
    cyc(1);
    integ_sel = SEL_INT0;
  endtask
  task automatic t_int();
    cyc(1);
    int_en = 1'b1;
    pulse_en = 1'b1;
    wait_new();
    wait_new();
    chk("in window", {15'h0, int_oe}, 16'h0000);
    cyc(1);
    thr_high = 16'h0000;
    wait_new();
    chk("above sets", {15'h0, int_oe}, 16'h0001);
    chk("pin low", {14'h0, int_line, int_o}, 16'h0000);
    cyc(1);
    alert_ack = 1'b1;
    cyc(1);
    alert_ack = 1'b0;
    chk("ack ignored", {15'h0, int_oe}, 16'h0001);
    int_clear = 1'b1;
    cyc(1);
    int_clear = 1'b0;
    chk("clear", {14'h0, int_oe, int_line}, 16'h0001);
    thr_high = 16'hFFFF;
    thr_low = 16'h0001;
    pulse_en = 1'b0;
    wait_new();
    wait_new();
    chk("below sets", {15'h0, int_oe}, 16'h0001);
    cyc(1);
    int_en = 1'b0;
    int_clear = 1'b1;
    cyc(1);
    int_clear = 1'b0;
    wait_new();
    chk("enable blocks", {15'h0, int_oe}, 16'h0000);
    cyc(1);
    int_en = 1'b1;
    persist = 4'h3;
    thr_low = 16'h0000;
    pulse_en = 1'b1;
    wait_new();
    wait_new();
    cyc(1);
    thr_high = 16'h0000;
    for (int k = 1; k <= 3; k++)
    begin
      wait_new();
      chk("persistence", {15'h0, int_oe}, {15'h0, k == 3});
    end
  endtask
  task automatic t_smb();
    cyc(1);
    variant_smb = 1'b1;
    addr_sel_gnd = 1'b1;
    persist = 4'h1;
    do_reset();
    cyc(3);
    chk("addr gnd", {9'h0, slave_addr}, 16'h0010);
    chk("khz smb", {7'h0, bus_khz}, 16'h0064);
    wait_new();
    chk("alert sets", {15'h0, int_oe}, 16'h0001);
    cyc(1);
    alert_ack = 1'b1;
    cyc(1);
    alert_ack = 1'b0;
    chk("alert ack", {15'h0, int_oe}, 16'h0000);
    addr_sel_gnd = 1'b0;
    addr_sel_vdd = 1'b1;
    do_reset();
    cyc(3);
    chk("addr vdd", {9'h0, slave_addr}, 16'h0012);
  endtask

  initial
  begin
    {sys_rst, power_on, gain_hi, int_en, int_clear, alert_ack} = 6'b111000;
    {variant_smb, addr_sel_gnd, addr_sel_vdd, pulse_en, ir_en, manual_go} = 6'b0;
    integ_sel = SEL_INT0;
    thr_low = 16'h0000;
    thr_high = 16'hFFFF;
    persist = 4'h1;
    err_total = 0;
    check_count = 0;
    tick = 0;
    do_reset();
    t_reset();
    t_conv();
    t_pwr();
    t_man();
    t_int();
    t_smb();
    results();
  end
endmodule
